// file: hw/rgd_pkg.sv
// Purpose: constants for the tag gap decoder and start marker block
// Assumes: field clock is the link clock, system clock 10 MHz
// Notes: register map sits on APB, word aligned
package rgd_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [11:0] RGD_CTRL_OFS = 12'h000;
	localparam logic [11:0] RGD_STAT_OFS = 12'h004;
	localparam logic [11:0] RGD_DATA_OFS = 12'h008;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int RGD_CTRL_XMODE_BIT = 0;
	localparam int RGD_CTRL_MARKER_BIT = 1;
	localparam int RGD_CTRL_INVERT_BIT = 2;
	localparam int RGD_CTRL_FAST_BIT = 3;
	localparam logic [3:0] RGD_CTRL_RST = 4'h0;
	localparam logic [1:0] RGD_MARKER_FIRST = 2'h1;
	// ****************************************
	// Field clock windows
	// ****************************************
	localparam logic [5:0] RGD_ZERO_MIN = 6'h08;
	localparam logic [5:0] RGD_ZERO_MAX = 6'h0F;
	localparam logic [5:0] RGD_ONE_MIN = 6'h18;
	localparam logic [5:0] RGD_ONE_MAX = 6'h1F;
	localparam logic [5:0] RGD_QUIET_MAX = 6'h20;
	localparam logic [5:0] RGD_CNT_SAT = 6'h3F;
	localparam logic [5:0] RGD_GAP_MIN = 6'h08;
	localparam logic [5:0] RGD_FAST_GAP_MAX = 6'h14;
	localparam logic [5:0] RGD_NORM_GAP_MAX = 6'h1E;
	localparam logic [5:0] RGD_START_GAP_MIN = 6'h0A;
	localparam logic [5:0] RGD_START_GAP_MAX = 6'h32;
endpackage

// file: hw/rgd_top.sv
// Purpose: gap decoder and sequence start marker for a tag
// Assumes: i_fld_clk is the extracted field clock, own domain
// Notes: gap symbols cross to system clock by toggle handshake
`timescale 1ns/1ps
module rgd_top
	import rgd_pkg::*;
(
	input wire logic i_sys_clk, // System clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_fld_clk, // Field clock from carrier
	input wire logic i_gap, // Gap detector, high in gap
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [11:0] i_paddr, // APB address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	input wire logic i_seq_start, // Pulse: new block sequence
	input wire logic i_data_bit, // Outgoing data bit
	output logic o_mod_bit, // Bit to the modulator
	output logic o_marker_active, // Marker bits being sent
	output logic o_write_mode, // Write mode active
	output logic o_sym_valid, // Pulse: symbol decoded
	output logic o_sym_bit, // Decoded symbol value
	output logic o_sym_err // Pulse: invalid symbol
);
	// ****************************************
	// Field clock domain
	// ****************************************
	logic gap_s1_reg, gap_s2_reg, gap_d_reg;
	logic [5:0] cnt_reg, gap_len_reg;
	logic wm_f_reg, first_reg, tgl_reg, sbit_f_reg, serr_f_reg;
	logic fast_f1_reg, fast_f2_reg;
	wire gap_rise = gap_s2_reg & ~gap_d_reg;
	wire gap_fall = ~gap_s2_reg & gap_d_reg;
	wire is_zero = cnt_reg >= RGD_ZERO_MIN && cnt_reg <= RGD_ZERO_MAX;
	wire is_one = cnt_reg >= RGD_ONE_MIN && cnt_reg <= RGD_ONE_MAX;
	wire [5:0] gap_max = fast_f2_reg ? RGD_FAST_GAP_MAX : RGD_NORM_GAP_MAX;
	wire gap_ok = first_reg ?
		(gap_len_reg >= RGD_START_GAP_MIN &&
		gap_len_reg <= RGD_START_GAP_MAX) :
		(gap_len_reg >= RGD_GAP_MIN && gap_len_reg <= gap_max);
	wire quiet = cnt_reg > RGD_QUIET_MAX;
	wire [5:0] cnt_inc = (cnt_reg == RGD_CNT_SAT) ? cnt_reg : cnt_reg + 6'h01;
	logic fast_q_reg;

	always_ff @(posedge i_fld_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			gap_s1_reg <= 1'b0;
			gap_s2_reg <= 1'b0;
			gap_d_reg <= 1'b0;
			fast_f1_reg <= 1'b0;
			fast_f2_reg <= 1'b0;
		end else begin
			gap_s1_reg <= i_gap;
			gap_s2_reg <= gap_s1_reg;
			gap_d_reg <= gap_s2_reg;
			fast_f1_reg <= fast_q_reg;
			fast_f2_reg <= fast_f1_reg;
		end
	end

	// Counter restarts on each gap start
	always_ff @(posedge i_fld_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg <= 6'h00;
			gap_len_reg <= 6'h00;
		end else begin
			cnt_reg <= gap_rise ? 6'h01 : cnt_inc;
			// Rise cycle is already the first gap clock
			if (gap_rise)
				gap_len_reg <= 6'h01;
			else if (gap_s2_reg)
				gap_len_reg <= (gap_len_reg == RGD_CNT_SAT) ?
					gap_len_reg : gap_len_reg + 6'h01;
		end
	end

	// Symbol decode on gap start, exit on long quiet
	always_ff @(posedge i_fld_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wm_f_reg <= 1'b0;
			first_reg <= 1'b1;
			tgl_reg <= 1'b0;
			sbit_f_reg <= 1'b0;
			serr_f_reg <= 1'b0;
		end else if (gap_rise && wm_f_reg) begin
			sbit_f_reg <= is_one;
			serr_f_reg <= ~(is_zero | is_one);
			tgl_reg <= ~tgl_reg;
		end else if (gap_fall && !wm_f_reg) begin
			wm_f_reg <= gap_ok;
			first_reg <= ~gap_ok;
		end else if (gap_fall && !gap_ok) begin
			wm_f_reg <= 1'b0;
			first_reg <= 1'b1;
		end else if (wm_f_reg && quiet && !gap_s2_reg) begin
			wm_f_reg <= 1'b0;
			first_reg <= 1'b1;
		end
	end

	// ****************************************
	// Crossing into system clock
	// ****************************************
	logic tg1_reg, tg2_reg, tg3_reg, wm1_reg, wm2_reg;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tg1_reg <= 1'b0;
			tg2_reg <= 1'b0;
			tg3_reg <= 1'b0;
			wm1_reg <= 1'b0;
			wm2_reg <= 1'b0;
		end else begin
			tg1_reg <= tgl_reg;
			tg2_reg <= tg1_reg;
			tg3_reg <= tg2_reg;
			wm1_reg <= wm_f_reg;
			wm2_reg <= wm1_reg;
		end
	end
	wire sym_evt = tg2_reg ^ tg3_reg;

	// Symbol data stable across the toggle, sampled after sync
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sym_valid <= 1'b0;
			o_sym_err <= 1'b0;
			o_sym_bit <= 1'b0;
		end else begin
			o_sym_valid <= sym_evt & ~serr_f_reg;
			o_sym_err <= sym_evt & serr_f_reg;
			if (sym_evt)
				o_sym_bit <= sbit_f_reg;
		end
	end
	assign o_write_mode = wm2_reg;

	// ****************************************
	// APB registers
	// ****************************************
	logic [3:0] ctrl_reg;
	logic [7:0] sym_cnt_reg, err_cnt_reg;
	logic [7:0] shift_reg;
	wire acc = i_psel & i_penable;
	wire sel_ctrl = i_paddr == RGD_CTRL_OFS;
	wire sel_stat = i_paddr == RGD_STAT_OFS;
	wire sel_data = i_paddr == RGD_DATA_OFS;
	wire mapped = sel_ctrl | sel_stat | sel_data;
	assign o_pready = 1'b1;
	assign o_pslverr = acc & ~mapped;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			ctrl_reg <= RGD_CTRL_RST;
		else if (acc && i_pwrite && sel_ctrl)
			ctrl_reg <= i_pwdata[3:0];
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			fast_q_reg <= 1'b0;
		else
			fast_q_reg <= ctrl_reg[RGD_CTRL_FAST_BIT];
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sym_cnt_reg <= 8'h00;
			err_cnt_reg <= 8'h00;
			shift_reg <= 8'h00;
		end else begin
			if (o_sym_valid) begin
				sym_cnt_reg <= sym_cnt_reg + 8'h01;
				shift_reg <= {shift_reg[6:0], o_sym_bit};
			end
			if (o_sym_err)
				err_cnt_reg <= err_cnt_reg + 8'h01;
		end
	end

	logic [1:0] marker_reg;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_prdata <= 32'h00000000;
		else if (i_psel && !i_penable && !i_pwrite)
			o_prdata <= sel_ctrl ? {28'h0000000, ctrl_reg} :
				sel_stat ? {13'h0000, marker_reg, o_write_mode,
				err_cnt_reg, sym_cnt_reg} :
				sel_data ? {24'h000000, shift_reg} : 32'h00000000;
	end

	// ****************************************
	// Start marker and inversion
	// ****************************************
	logic [1:0] mk_cnt_reg;
	wire xm = ctrl_reg[RGD_CTRL_XMODE_BIT];
	wire mk_en = xm & ctrl_reg[RGD_CTRL_MARKER_BIT];
	wire inv_en = xm & ctrl_reg[RGD_CTRL_INVERT_BIT];
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			marker_reg <= RGD_MARKER_FIRST;
			mk_cnt_reg <= 2'h0;
		end else if (i_seq_start && mk_en) begin
			marker_reg <= ~marker_reg;
			mk_cnt_reg <= 2'h2;
		end else if (mk_cnt_reg != 2'h0) begin
			mk_cnt_reg <= mk_cnt_reg - 2'h1;
		end
	end
	// Marker sent uninverted: it is complemented on each marked sequence
	// First marker bit loads with the count, so it lines up with active
	wire mk_go = i_seq_start & mk_en;
	wire [1:0] mk_new = ~marker_reg;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_mod_bit <= 1'b0;
		else if (mk_go)
			o_mod_bit <= mk_new[1];
		else if (mk_cnt_reg == 2'h2)
			o_mod_bit <= marker_reg[0];
		else
			o_mod_bit <= i_data_bit ^ inv_en;
	end
	assign o_marker_active = mk_cnt_reg != 2'h0;

	// ****************************************
	// Checks
	// ****************************************
	property p_marker_flip;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_seq_start && mk_en) |=> marker_reg == ~$past(marker_reg);
	endproperty
	a_marker_flip: assert property (p_marker_flip)
		else $error("marker not complemented");
	property p_marker_len;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_seq_start && mk_en) |=> o_marker_active [*2] ##1 !o_marker_active;
	endproperty
	a_marker_len: assert property (p_marker_len)
		else $error("marker length wrong");
	property p_invert;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(!o_marker_active && !mk_go)
		|=> o_mod_bit == ($past(i_data_bit) ^ $past(inv_en));
	endproperty
	a_invert: assert property (p_invert)
		else $error("inversion wrong");
	property p_quiet_exit;
		@(posedge i_fld_clk) disable iff (!i_rstn)
		(wm_f_reg && quiet && !gap_s2_reg && !gap_rise && !gap_fall)
		|=> !wm_f_reg;
	endproperty
	a_quiet_exit: assert property (p_quiet_exit)
		else $error("write mode kept after quiet");
	property p_cnt_restart;
		@(posedge i_fld_clk) disable iff (!i_rstn)
		gap_rise |=> cnt_reg == 6'h01;
	endproperty
	a_cnt_restart: assert property (p_cnt_restart)
		else $error("counter not restarted");
	property p_bad_sym;
		@(posedge i_fld_clk) disable iff (!i_rstn)
		(gap_rise && wm_f_reg && cnt_reg > 6'h0F && cnt_reg < 6'h18)
		|=> serr_f_reg;
	endproperty
	a_bad_sym: assert property (p_bad_sym)
		else $error("invalid interval accepted");
	property p_one_sym;
		@(posedge i_fld_clk) disable iff (!i_rstn)
		(gap_rise && wm_f_reg && cnt_reg >= 6'h18 && cnt_reg <= 6'h1F)
		|=> sbit_f_reg && !serr_f_reg;
	endproperty
	a_one_sym: assert property (p_one_sym)
		else $error("one symbol misread");
	property p_start_gap;
		@(posedge i_fld_clk) disable iff (!i_rstn)
		(gap_fall && !wm_f_reg && gap_len_reg < 6'h0A) |=> !wm_f_reg;
	endproperty
	a_start_gap: assert property (p_start_gap)
		else $error("short start gap accepted");
endmodule

// file: testbench/rgd_reader.sv
// Purpose: reader model, field clock and gaps
// Assumes: gap line high while the field is off
// Notes: three symbols per session (32, 12, then sp clocks), then a long quiet
`timescale 1ns/1ps
module rgd_reader (
	output logic o_fld_clk, // Field clock
	output logic o_gap // High in a field gap
);
	initial o_fld_clk = 1'b0;
	initial o_gap = 1'b0;
	// Free running so gap widths can be counted
	always #6 o_fld_clk = ~o_fld_clk;
	task automatic fc(input int n);
		repeat (n) @(posedge o_fld_clk);
	endtask
	task automatic gap(input int w, input int sp);
		o_gap <= 1'b1;
		fc(w);
		o_gap <= 1'b0;
		fc(sp - w);
	endtask
	task automatic session(input int sp);
		fc(1);
		gap(20, 32);
		gap(8, 12);
		gap(8, sp);
		gap(8, 60);
	endtask
endmodule

// file: testbench/tb_top.sv
// Purpose: bench for gap decoder and start marker
// Assumes: zero wait APB slave, reader model
// Notes: only the last symbol of a session is judged
`timescale 1ns/1ps
module tb_top import rgd_pkg::*;;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
	logic start = 0, dbit = 1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdat = 32'h0, q, prdata;
	logic e, fclk, gap, pready, pslverr, mod, act, wm, sv, sb, se;
	logic [1:0] last_ev;
	logic wm_seen;
	logic clr = 1'b0;
	int error_cnt = 0, checks = 0;
	int sp[8] = '{10, 12, 15, 16, 23, 24, 27, 31};
	logic [1:0] ex[8] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
	always #50 clk = ~clk;
	rgd_reader rdr (.o_fld_clk(fclk), .o_gap(gap));
	rgd_top uut (.i_sys_clk(clk), .i_rstn(rstn), .i_fld_clk(fclk),
		.i_gap(gap), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_seq_start(start),
		.i_data_bit(dbit), .o_mod_bit(mod), .o_marker_active(act),
		.o_write_mode(wm), .o_sym_valid(sv), .o_sym_bit(sb),
		.o_sym_err(se));
	always @(posedge clk) begin
		if (clr) begin
			last_ev <= 2'b11;
			wm_seen <= 1'b0;
		end else begin
			if (sv === 1'b1) last_ev <= {1'b0, sb};
			if (se === 1'b1) last_ev <= 2'b10;
			if (wm === 1'b1) wm_seen <= 1'b1;
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 20) begin
			error_cnt++;
			complete_run();
		end
	endtask
	// Marker bits, then the data bit, one per cycle
	task automatic seq(input logic [2:0] m, input logic a);
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (int i = 2; i >= 0; i--) begin
			@(negedge clk);
			cmp("mod_bit", m[i], mod);
			cmp("marker_active", (i > 0) ? a : 1'b0, act);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b1, RGD_CTRL_OFS, 32'h3);
		apb(1'b0, RGD_CTRL_OFS, 32'h0);
		cmp("ctrl", 32'h3, q);
		apb(1'b1, 12'h00C, 32'h5);
		cmp("pslverr", 32'h1, e);
		apb(1'b0, 12'h00C, 32'h0);
		cmp("unmapped", 32'h0, q);
		seq(3'b101, 1'b1);
		apb(1'b1, RGD_CTRL_OFS, 32'h7);
		seq(3'b010, 1'b1);
		apb(1'b1, RGD_CTRL_OFS, 32'h1);
		seq(3'b111, 1'b0);
		apb(1'b1, RGD_CTRL_OFS, 32'h3);
		seq(3'b101, 1'b1);
		apb(1'b0, RGD_STAT_OFS, 32'h0);
		cmp("last marker", 32'h2, {30'h0, q[18:17]});
		$display("marker test done");
		apb(1'b1, RGD_CTRL_OFS, 32'h8);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			rdr.session(sp[i]);
			repeat (40) @(posedge clk);
			cmp("symbol", ex[i], last_ev);
			cmp("entered", 32'h1, wm_seen);
			cmp("write_mode", 32'h0, wm);
		end
		apb(1'b0, RGD_STAT_OFS, 32'h0);
		cmp("stat mode", 32'h0, q[16]);
		$display("decode test done");
		complete_run();
	end
endmodule
